// ### pmpg_core.sv
// Programmed move profile generator: constants package and single-axis core
`default_nettype none

// ************************************************************
// Constants
// ************************************************************
package pmpg_pkg;
  localparam int POS_W = 32;
  localparam int SPD_W = 24;
  localparam int IDX_W = 8;
  localparam int N_OPR = 256;
  localparam int CNT_W = 18;
  // Position-loop update periods, in milliseconds
  localparam real CLK_MHZ = 100.0;
  localparam real LOOP_A_MS = 0.5;
  localparam real LOOP_B_MS = 1.0;
  localparam real LOOP_C_MS = 2.0;
  localparam int TICK_A_CYC = int'(LOOP_A_MS * 1000.0 * CLK_MHZ);
  localparam int TICK_B_CYC = int'(LOOP_B_MS * 1000.0 * CLK_MHZ);
  localparam int TICK_C_CYC = int'(LOOP_C_MS * 1000.0 * CLK_MHZ);
  localparam logic [1:0] SEL_A = 2'h0;
  localparam logic [1:0] SEL_B = 2'h1;
  // Pause ticks per millisecond at the 0.5 ms rate, as a shift
  localparam int PAUSE_SHL = 1;
  localparam logic [SPD_W-1:0] SPD_ZERO = 24'h000000;
  localparam logic [SPD_W-1:0] SPD_CREEP = 24'h000001;
  typedef enum logic [2:0] {
    PMPG_OP_MOVE, PMPG_OP_SPEED, PMPG_OP_RATE, PMPG_OP_PAUSE, PMPG_OP_END
  } pmpg_op_t;
  typedef enum logic [2:0] {
    ST_IDLE, ST_LOOK, ST_RUN, ST_SETTLE, ST_PAUSE
  } pmpg_state_t;
endpackage

// Notes on behaviour
// - Absolute operand is destination; no travel if there
// - Relative operand added to target, made absolute
// - Linear: constant rate equal to programmed acceleration
// - S-curve: acceleration peaks mid-change, returns to zero
// - S-curve change takes double time and distance
// - Stop move ends still, waits for settled flag
// - Latest speed and rate used, else jog defaults
// - Blend stops only before pause, zero speed, end
// - Blend reaches target at next move's speed
// - Zero relative blend defers change to next move
// - Short move accelerates only until braking needed
// - Equal-speed blends finish with no speed change
// - Operand from immediate or stored registers 0-255
// - Profile steps at selected loop period
// - Zero-length pause skipped, blend continues
module pmpg_core #(
  parameter int TICK_A_CYC = pmpg_pkg::TICK_A_CYC,
  parameter int TICK_B_CYC = pmpg_pkg::TICK_B_CYC,
  parameter int TICK_C_CYC = pmpg_pkg::TICK_C_CYC
) (
  input  wire logic                              clk,
  input  wire logic                              rst,
  input  wire logic [1:0]                        loop_sel,
  input  wire logic [pmpg_pkg::SPD_W-1:0]        jog_speed,
  input  wire logic [pmpg_pkg::SPD_W-1:0]        jog_rate,
  input  wire logic                              prog_start,
  input  wire logic                              cmd_valid,
  output var  logic                              cmd_ready,
  input  wire pmpg_pkg::pmpg_op_t                cmd_op,
  input  wire logic                              cmd_stop,
  input  wire logic                              cmd_rel,
  input  wire logic                              cmd_scurve,
  input  wire logic                              cmd_from_reg,
  input  wire logic [pmpg_pkg::IDX_W-1:0]        cmd_reg_idx,
  input  wire logic signed [pmpg_pkg::POS_W-1:0] cmd_value,
  input  wire logic                              opr_wr,
  input  wire logic [pmpg_pkg::IDX_W-1:0]        opr_wr_idx,
  input  wire logic signed [pmpg_pkg::POS_W-1:0] opr_wr_data,
  input  wire logic                              settled,
  output var  logic signed [pmpg_pkg::POS_W-1:0] cmd_pos,
  output var  logic signed [pmpg_pkg::SPD_W:0]   cmd_vel,
  output var  logic                              in_motion,
  output var  logic                              update_tick,
  output var  logic                              prog_done
);
  localparam int PW = pmpg_pkg::POS_W;
  localparam int SW = pmpg_pkg::SPD_W;

  // ************************************************************
  // Update tick
  // ************************************************************
  logic [pmpg_pkg::CNT_W-1:0] tick_cnt, next_tick_cnt, period;
  logic                       tick, next_tick;

  // Divider restarts each period; a changed selection applies at once to the running count
  always_comb begin
    case (loop_sel)
      pmpg_pkg::SEL_A: period = pmpg_pkg::CNT_W'(TICK_A_CYC - 1);
      pmpg_pkg::SEL_B: period = pmpg_pkg::CNT_W'(TICK_B_CYC - 1);
      default:         period = pmpg_pkg::CNT_W'(TICK_C_CYC - 1);
    endcase
    next_tick = (tick_cnt >= period);
    next_tick_cnt = next_tick ? '0 : tick_cnt + 1'b1;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      tick_cnt <= '0;
      tick <= 1'b0;
    end else begin
      tick_cnt <= next_tick_cnt;
      tick <= next_tick;
    end
  end

  // ************************************************************
  // Stored operand registers
  // ************************************************************
  logic signed [PW-1:0] opr [pmpg_pkg::N_OPR];

  // Plain storage, written by the host at any time
  always_ff @(posedge clk) begin
    if (opr_wr) begin
      opr[opr_wr_idx] <= opr_wr_data;
    end
  end

  // ************************************************************
  // Command sequencing and profile
  // ************************************************************
  pmpg_pkg::pmpg_state_t state, next_state;
  pmpg_pkg::pmpg_op_t    pend_op, next_pend_op, src_op;
  logic                  pend_v, pend_stop, pend_rel, pend_sc;
  logic                  next_pend_v, next_pend_stop, next_pend_rel, next_pend_sc;
  logic signed [PW-1:0]  pend_val, next_pend_val, port_val, src_val;
  logic                  src_stop, src_rel, src_sc, take, look_take, marker;
  logic signed [PW-1:0]  tgt, next_tgt, pos, next_pos, dest;
  logic [SW-1:0]         spd, next_spd, top, next_top, end_spd, next_end;
  logic [SW-1:0]         rate_c, next_rate_c, spd_prog, next_spd_prog;
  logic [SW-1:0]         rate_prog, next_rate_prog, eff_spd, eff_rate;
  logic                  dir, next_dir, sc, next_sc, stop, next_stop;
  logic                  defer, next_defer, spd_set, next_spd_set;
  logic                  rate_set, next_rate_set, done, next_done;
  logic                  next_ready;
  logic [PW-1:0]         pause_cnt, next_pause;
  logic [SW-1:0]         acur, next_acur, jerk, next_jerk, dvtot, next_dvtot;
  logic [SW-1:0]         goal, goal_q, next_goal_q, step, dv, spd_n;
  logic signed [PW:0]    rem;
  logic [2*SW-1:0]       diff, rr;
  logic [63:0]           lim, lim_lin;
  logic                  brake, arrive;

  // Operand source: pending command replays before new port commands
  always_comb begin
    port_val = cmd_from_reg ? opr[cmd_reg_idx] : cmd_value;
    src_op   = pend_v ? pend_op : cmd_op;
    src_stop = pend_v ? pend_stop : cmd_stop;
    src_rel  = pend_v ? pend_rel : cmd_rel;
    src_sc   = pend_v ? pend_sc : cmd_scurve;
    src_val  = pend_v ? pend_val : port_val;
    take = (state == pmpg_pkg::ST_IDLE) && (pend_v || (cmd_valid && cmd_ready));
    look_take = (state == pmpg_pkg::ST_LOOK) && cmd_valid && cmd_ready;
    marker = (src_op == pmpg_pkg::PMPG_OP_MOVE) && !src_stop && src_rel
             && (src_val == '0);
    dest = src_rel ? tgt + src_val : src_val;
    eff_spd = spd_set ? spd_prog : jog_speed;
    eff_rate = rate_set ? rate_prog : jog_rate;
  end

  // Braking point and S-curve shaping of the step size
  always_comb begin
    rem = dir ? {pos[PW-1], pos} - {tgt[PW-1], tgt} : {tgt[PW-1], tgt} - {pos[PW-1], pos};
    diff = (spd > end_spd) ? spd * spd - end_spd * end_spd : '0;
    lim_lin = 64'(rate_c * rem[PW-1:0]) << 1;
    lim = sc ? 64'(rate_c * rem[PW-1:0]) : lim_lin;
    // Decelerate once the remaining distance only just covers the change.
    // Braking is held once begun (last goal was the end speed); otherwise
    // rounding can flip back to speeding up and snap the speed at arrival.
    brake = (spd > end_spd) && (64'(diff) >= lim || goal_q == end_spd);
    goal = brake ? end_spd : top;
    dv = (goal > spd) ? goal - spd : spd - goal;
    rr = rate_c * rate_c;
    next_goal_q = goal;
    next_dvtot = dvtot;
    next_jerk = jerk;
    next_acur = acur;
    if (goal != goal_q) begin
      // New phase: jerk sized so the ramp peaks half way through
      next_dvtot = dv;
      next_jerk = (dv == '0 || rr / dv >= 48'(rate_c)) ? rate_c : SW'(rr / dv);
      if (next_jerk == '0) next_jerk = pmpg_pkg::SPD_CREEP;
      next_acur = next_jerk;
    end else if (25'(dv) << 1 > 25'(dvtot)) begin
      next_acur = (acur + jerk > rate_c) ? rate_c : acur + jerk;
    end else begin
      next_acur = (acur > jerk + jerk) ? acur - jerk : jerk;
    end
    step = sc ? next_acur : rate_c;
    if (spd < goal) spd_n = (goal - spd > step) ? spd + step : goal;
    else spd_n = (spd - goal > step) ? spd - step : goal;
    // Never stall short of the target, even with a zero end speed
    if (spd_n == '0 && rem > 0) spd_n = pmpg_pkg::SPD_CREEP;
    arrive = (rem <= $signed({9'h000, spd_n}));
  end

  // Sequencer: decode, lookahead for blends, run, settle and pause
  always_comb begin
    next_state = state;
    next_pend_v = pend_v;
    next_pend_op = pend_op;
    next_pend_stop = pend_stop;
    next_pend_rel = pend_rel;
    next_pend_sc = pend_sc;
    next_pend_val = pend_val;
    next_tgt = tgt;
    next_pos = pos;
    next_spd = spd;
    next_dir = dir;
    next_top = top;
    next_rate_c = rate_c;
    next_sc = sc;
    next_stop = stop;
    next_end = end_spd;
    next_defer = defer;
    next_spd_prog = spd_prog;
    next_rate_prog = rate_prog;
    next_spd_set = spd_set && !prog_start;
    next_rate_set = rate_set && !prog_start;
    next_done = done && !prog_start;
    next_pause = pause_cnt;
    if (take || look_take) begin
      if (pend_v) next_pend_v = 1'b0;
      case (src_op)
        pmpg_pkg::PMPG_OP_SPEED: begin
          next_spd_prog = src_val[SW-1:0];
          next_spd_set = 1'b1;
        end
        pmpg_pkg::PMPG_OP_RATE: begin
          next_rate_prog = src_val[SW-1:0];
          next_rate_set = 1'b1;
        end
        default: begin
        end
      endcase
    end
    case (state)
      pmpg_pkg::ST_IDLE: begin
        if (take) begin
          next_done = 1'b0;
          case (src_op)
            pmpg_pkg::PMPG_OP_PAUSE: begin
              if (src_val != '0) begin
                next_pause = src_val << pmpg_pkg::PAUSE_SHL >> loop_sel;
                if (next_pause == '0) next_pause = PW'(1);
                next_state = pmpg_pkg::ST_PAUSE;
              end
            end
            pmpg_pkg::PMPG_OP_END: next_done = 1'b1;
            pmpg_pkg::PMPG_OP_MOVE: begin
              if (!marker) begin
                next_tgt = dest;
                if (spd == '0) next_dir = (dest < pos);
                next_top = eff_spd;
                next_rate_c = eff_rate;
                next_sc = src_sc;
                next_stop = src_stop;
                next_end = pmpg_pkg::SPD_ZERO;
                next_defer = 1'b0;
                next_state = src_stop ? pmpg_pkg::ST_RUN : pmpg_pkg::ST_LOOK;
              end
            end
            default: begin
            end
          endcase
        end
      end
      pmpg_pkg::ST_LOOK: begin
        if (look_take) begin
          if (marker) begin
            next_defer = 1'b1;
          end else if (src_op == pmpg_pkg::PMPG_OP_MOVE
                       || src_op == pmpg_pkg::PMPG_OP_END
                       || (src_op == pmpg_pkg::PMPG_OP_PAUSE && src_val != '0)) begin
            // Blend end speed is known once the following move shows up
            next_pend_v = 1'b1;
            next_pend_op = src_op;
            next_pend_stop = src_stop;
            next_pend_rel = src_rel;
            next_pend_sc = src_sc;
            next_pend_val = src_val;
            if (src_op == pmpg_pkg::PMPG_OP_MOVE && eff_spd != '0)
              next_end = defer ? top : eff_spd;
            next_state = pmpg_pkg::ST_RUN;
          end
        end
      end
      pmpg_pkg::ST_SETTLE: begin
        if (settled) next_state = pmpg_pkg::ST_IDLE;
      end
      pmpg_pkg::ST_PAUSE: begin
        if (tick) begin
          next_pause = pause_cnt - 1'b1;
          if (pause_cnt <= PW'(1)) next_state = pmpg_pkg::ST_IDLE;
        end
      end
      default: begin
      end
    endcase
    // Profile advances only on the update tick, in lookahead and run
    if (tick && (state == pmpg_pkg::ST_RUN || state == pmpg_pkg::ST_LOOK)) begin
      if (arrive) begin
        next_pos = tgt;
        next_spd = end_spd;
        if (state == pmpg_pkg::ST_RUN)
          next_state = stop ? pmpg_pkg::ST_SETTLE : pmpg_pkg::ST_IDLE;
      end else begin
        next_spd = spd_n;
        next_pos = dir ? pos - PW'(spd_n) : pos + PW'(spd_n);
      end
    end
    next_ready = (next_state == pmpg_pkg::ST_IDLE && !next_pend_v)
                 || next_state == pmpg_pkg::ST_LOOK;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state <= pmpg_pkg::ST_IDLE;
      pend_v <= 1'b0;
      pend_op <= pmpg_pkg::PMPG_OP_END;
      {pend_stop, pend_rel, pend_sc} <= 3'h0;
      pend_val <= '0;
      {tgt, pos} <= '0;
      {spd, top, end_spd, rate_c, spd_prog, rate_prog} <= '0;
      {dir, sc, stop, defer, spd_set, rate_set, done} <= 7'h00;
      pause_cnt <= '0;
      {acur, jerk, dvtot, goal_q} <= '0;
      cmd_ready <= 1'b0;
      cmd_pos <= '0;
      cmd_vel <= '0;
      in_motion <= 1'b0;
      update_tick <= 1'b0;
      prog_done <= 1'b0;
    end else begin
      state <= next_state;
      pend_v <= next_pend_v;
      pend_op <= next_pend_op;
      {pend_stop, pend_rel, pend_sc} <= {next_pend_stop, next_pend_rel, next_pend_sc};
      pend_val <= next_pend_val;
      {tgt, pos} <= {next_tgt, next_pos};
      {spd, top, end_spd, rate_c} <= {next_spd, next_top, next_end, next_rate_c};
      {spd_prog, rate_prog} <= {next_spd_prog, next_rate_prog};
      {dir, sc, stop, defer} <= {next_dir, next_sc, next_stop, next_defer};
      {spd_set, rate_set, done} <= {next_spd_set, next_rate_set, next_done};
      pause_cnt <= next_pause;
      if (tick) {acur, jerk, dvtot, goal_q} <= {next_acur, next_jerk, next_dvtot, next_goal_q};
      cmd_ready <= next_ready;
      cmd_pos <= next_pos;
      cmd_vel <= next_dir ? -$signed({1'b0, next_spd}) : $signed({1'b0, next_spd});
      in_motion <= (next_spd != '0);
      update_tick <= tick;
      prog_done <= next_done;
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  chk_abs_dest: assert property (
    take && src_op == pmpg_pkg::PMPG_OP_MOVE && !src_rel |=> tgt == $past(src_val)
  ) else $error("absolute move target wrong");
  chk_rel_dest: assert property (
    take && src_op == pmpg_pkg::PMPG_OP_MOVE && src_rel |=> tgt == $past(tgt) + $past(src_val)
  ) else $error("relative move target wrong");
  chk_lin_rate: assert property (
    tick && state == pmpg_pkg::ST_RUN && !sc && !arrive && spd > rate_c
    |=> (spd > $past(spd) ? spd - $past(spd) : $past(spd) - spd) <= $past(rate_c)
  ) else $error("linear step exceeds rate");
  chk_sc_peak: assert property (
    state == pmpg_pkg::ST_RUN && sc |-> ##1 acur <= $past(rate_c)
  ) else $error("s-curve acceleration above peak");
  chk_sc_earlier: assert property (
    state == pmpg_pkg::ST_RUN && sc && !brake && spd > end_spd |-> 64'(diff) < lim_lin
  ) else $error("s-curve braking later than linear");
  chk_settle_hold: assert property (
    state == pmpg_pkg::ST_SETTLE && !settled |=> state == pmpg_pkg::ST_SETTLE && spd == '0
  ) else $error("left settle without flag");
  chk_jog_fallback: assert property (
    take && src_op == pmpg_pkg::PMPG_OP_MOVE && !marker && !spd_set |=> top == $past(jog_speed)
  ) else $error("jog speed not used");
  chk_blend_nowait: assert property (
    tick && state == pmpg_pkg::ST_RUN && !stop && arrive |=> state == pmpg_pkg::ST_IDLE
  ) else $error("blend waited at end");
  chk_marker_hold: assert property (
    look_take && marker |=> defer && state == pmpg_pkg::ST_LOOK
  ) else $error("marker not deferred");
  chk_zero_pause: assert property (
    take && src_op == pmpg_pkg::PMPG_OP_PAUSE && src_val == '0 |=> state == pmpg_pkg::ST_IDLE
  ) else $error("zero pause not skipped");
  chk_pos_step: assert property (
    tick && state == pmpg_pkg::ST_RUN && !arrive |=> 33'(cmd_pos - $past(cmd_pos)) == 33'(cmd_vel)
  ) else $error("position step differs from velocity");
  chk_tick_gap: assert property (
    tick |=> !tick
  ) else $error("update ticks adjacent");
endmodule

`default_nettype wire

// ### pmpg_servo_model.sv
// Behavioural servo loop that follows the commanded position and reports settling
`default_nettype none

// ************************************************************
// Servo follower
// ************************************************************
module pmpg_servo_model #(
  parameter int SETTLE_CYC = 6
) (
  input  wire logic                              clk,
  input  wire logic                              rst,
  input  wire logic signed [pmpg_pkg::POS_W-1:0] cmd_pos,
  input  wire logic signed [pmpg_pkg::SPD_W:0]   cmd_vel,
  output var  logic                              settled,
  output var  logic                              settle_seen
);
  timeunit 1ns;
  timeprecision 1ps;
  logic signed [pmpg_pkg::POS_W-1:0] act_pos;
  logic signed [pmpg_pkg::POS_W-1:0] err;
  int                                still_cnt;

  // Actual axis lags by half the error each cycle, so settling is never instant
  always @(posedge clk) begin
    err = cmd_pos - act_pos;
    if (rst) begin
      act_pos <= '0;
      still_cnt <= 0;
    end else begin
      if (err > 1 || err < -1) act_pos <= act_pos + (err >>> 1);
      else act_pos <= cmd_pos;
      if (err == 0 && cmd_vel == 0) still_cnt <= still_cnt + 1;
      else still_cnt <= 0;
    end
  end

  assign settled = (still_cnt >= SETTLE_CYC);

  // Cleared by any motion, so a set flag means settling followed the last move
  always @(posedge clk) begin
    if (rst || cmd_vel != 0) settle_seen <= 1'b0;
    else if (settled) settle_seen <= 1'b1;
  end
endmodule
`default_nettype wire

// ### programmed_move_profile_generator_tb_top.sv
// Self-checking testbench for the single-axis move profile generator
`default_nettype none

module programmed_move_profile_generator_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [1:0] loop_sel = 2'h0;
  logic [23:0] jog_speed = 24'h00000a;
  logic [23:0] jog_rate = 24'h00000a;
  logic prog_start = 1'b0;
  logic cmd_valid = 1'b0;
  logic cmd_ready;
  pmpg_pkg::pmpg_op_t cmd_op = pmpg_pkg::PMPG_OP_END;
  logic cmd_stop = 1'b0;
  logic cmd_rel = 1'b0;
  logic cmd_scurve = 1'b0;
  logic cmd_from_reg = 1'b0;
  logic [7:0] cmd_reg_idx = 8'h00;
  logic signed [31:0] cmd_value = 32'sh0;
  logic opr_wr = 1'b0;
  logic [7:0] opr_wr_idx = 8'h00;
  logic signed [31:0] opr_wr_data = 32'sh0;
  logic settled;
  logic settle_seen;
  logic signed [31:0] cmd_pos;
  logic signed [24:0] cmd_vel;
  logic in_motion;
  logic update_tick;
  logic prog_done;
  int n_mismatch = 0;
  int tests_run = 0;
  int cycles = 0;
  int cap_spd = 10;
  int cap_rate = 10;
  int last_vel = 0;
  logic signed [24:0] vel_at_600 = 25'sh0;
  logic seen_600 = 1'b0;

  always #5 clk = ~clk;

  // ************************************************************
  // Design and servo partner
  // ************************************************************
  pmpg_core #(.TICK_A_CYC(8), .TICK_B_CYC(16), .TICK_C_CYC(32)) i_pmpg_core (
    .clk(clk), .rst(rst), .loop_sel(loop_sel), .jog_speed(jog_speed), .jog_rate(jog_rate),
    .prog_start(prog_start), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op),
    .cmd_stop(cmd_stop), .cmd_rel(cmd_rel), .cmd_scurve(cmd_scurve),
    .cmd_from_reg(cmd_from_reg), .cmd_reg_idx(cmd_reg_idx), .cmd_value(cmd_value),
    .opr_wr(opr_wr), .opr_wr_idx(opr_wr_idx), .opr_wr_data(opr_wr_data), .settled(settled),
    .cmd_pos(cmd_pos), .cmd_vel(cmd_vel), .in_motion(in_motion),
    .update_tick(update_tick), .prog_done(prog_done));

  pmpg_servo_model i_pmpg_servo_model (
    .clk(clk), .rst(rst), .cmd_pos(cmd_pos), .cmd_vel(cmd_vel), .settled(settled),
    .settle_seen(settle_seen));

  // ************************************************************
  // Reporting
  // ************************************************************
  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk_val(input logic signed [31:0] got, input logic signed [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got %0d expected %0d", $time, got, exp);
    end
  endtask

  // Hang guard, well above the thousand or so cycles the sequence needs
  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      n_mismatch++;
      give_verdict();
    end
  end

  // Each tick: speed stays under the cap and changes by at most the rate
  always @(posedge clk) if (!rst && update_tick === 1'b1) begin
    chk_val(32'(cmd_vel <= cap_spd && cmd_vel >= -cap_spd), 32'sh1);
    chk_val(32'(int'(cmd_vel) - last_vel <= cap_rate && last_vel - int'(cmd_vel) <= cap_rate),
            32'sh1);
    last_vel = int'(cmd_vel);
    if (!seen_600 && cmd_pos >= 600) begin
      seen_600 <= 1'b1;
      vel_at_600 <= cmd_vel;
    end
  end

  // ************************************************************
  // Command port access
  // ************************************************************
  task automatic send(input pmpg_pkg::pmpg_op_t op, input logic stp, input logic rel,
                      input logic sc, input logic frg, input logic [7:0] idx,
                      input logic signed [31:0] val);
    int n;
    n = 0;
    cmd_op <= op;
    cmd_stop <= stp;
    cmd_rel <= rel;
    cmd_scurve <= sc;
    cmd_from_reg <= frg;
    cmd_reg_idx <= idx;
    cmd_value <= val;
    cmd_valid <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (cmd_ready !== 1'b1 && n < 5000);
    if (cmd_ready !== 1'b1) begin
      n_mismatch++;
      $display("MISMATCH t=%0t command never taken", $time);
    end
    cmd_valid <= 1'b0;
    // One idle edge keeps valid from being lowered and raised in one time step
    @(posedge clk);
  endtask

  task automatic wait_idle();
    int n;
    n = 0;
    @(posedge clk);
    while ((cmd_ready !== 1'b1 || in_motion !== 1'b0) && n < 20000) begin
      @(posedge clk);
      n++;
    end
    if (cmd_ready !== 1'b1 || in_motion !== 1'b0) begin
      n_mismatch++;
      $display("MISMATCH t=%0t axis never came to rest", $time);
    end
  endtask

  task automatic tick_gap(output int gap);
    gap = 0;
    while (update_tick !== 1'b1 && gap < 100) begin @(posedge clk); gap++; end
    gap = 0;
    do begin @(posedge clk); gap++; end while (update_tick !== 1'b1 && gap < 100);
  endtask

  // ************************************************************
  // Test sequence
  // ************************************************************
  initial begin
    int gap;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    chk_val(cmd_pos, 32'sh0);
    prog_start <= 1'b1;
    @(posedge clk);
    prog_start <= 1'b0;
    tick_gap(gap);
    chk_val(gap, 32'sh8);
    loop_sel <= 2'h1;
    tick_gap(gap);
    tick_gap(gap);
    chk_val(gap, 32'sh10);
    loop_sel <= 2'h2;
    tick_gap(gap);
    tick_gap(gap);
    chk_val(gap, 32'sh20);
    loop_sel <= 2'h0;
    // Jog defaults, absolute stop move, then the same target again
    send(pmpg_pkg::PMPG_OP_MOVE, 1'b1, 1'b0, 1'b0, 1'b0, 8'h00, 32'sh64);
    wait_idle();
    chk_val(cmd_pos, 32'sh64);
    chk_val(32'(settle_seen), 32'sh1);
    send(pmpg_pkg::PMPG_OP_MOVE, 1'b1, 1'b0, 1'b0, 1'b0, 8'h00, 32'sh64);
    wait_idle();
    chk_val(cmd_pos, 32'sh64);
    // Relative move from the top stored operand register
    opr_wr <= 1'b1;
    opr_wr_idx <= 8'hff;
    opr_wr_data <= 32'sh32;
    @(posedge clk);
    opr_wr <= 1'b0;
    send(pmpg_pkg::PMPG_OP_MOVE, 1'b1, 1'b1, 1'b0, 1'b1, 8'hff, 32'sh0);
    wait_idle();
    chk_val(cmd_pos, 32'sh96);
    // Programmed speed and rate with an S-curve stop move
    send(pmpg_pkg::PMPG_OP_SPEED, 1'b0, 1'b0, 1'b0, 1'b0, 8'h00, 32'sh14);
    send(pmpg_pkg::PMPG_OP_RATE, 1'b0, 1'b0, 1'b0, 1'b0, 8'h00, 32'sha);
    cap_spd = 20;
    cap_rate = 10;
    send(pmpg_pkg::PMPG_OP_MOVE, 1'b1, 1'b0, 1'b1, 1'b0, 8'h00, 32'sh190);
    wait_idle();
    chk_val(cmd_pos, 32'sh190);
    chk_val(cmd_vel, 32'sh0);
    // Blend at full speed past 600 with a marker and a skipped zero pause
    send(pmpg_pkg::PMPG_OP_MOVE, 1'b0, 1'b0, 1'b0, 1'b0, 8'h00, 32'sh258);
    send(pmpg_pkg::PMPG_OP_MOVE, 1'b0, 1'b1, 1'b0, 1'b0, 8'h00, 32'sh0);
    send(pmpg_pkg::PMPG_OP_SPEED, 1'b0, 1'b0, 1'b0, 1'b0, 8'h00, 32'sha);
    send(pmpg_pkg::PMPG_OP_PAUSE, 1'b0, 1'b0, 1'b0, 1'b0, 8'h00, 32'sh0);
    send(pmpg_pkg::PMPG_OP_MOVE, 1'b1, 1'b0, 1'b1, 1'b0, 8'h00, 32'sh320);
    wait_idle();
    chk_val(vel_at_600, 32'sh14);
    chk_val(cmd_pos, 32'sh320);
    // Blend followed by a timed pause comes to rest at its target
    send(pmpg_pkg::PMPG_OP_MOVE, 1'b0, 1'b0, 1'b0, 1'b0, 8'h00, 32'sh352);
    send(pmpg_pkg::PMPG_OP_PAUSE, 1'b0, 1'b0, 1'b0, 1'b0, 8'h00, 32'sh1);
    wait_idle();
    chk_val(cmd_pos, 32'sh352);
    chk_val(cmd_vel, 32'sh0);
    // Short blend that cannot reach its speed, ending the program
    send(pmpg_pkg::PMPG_OP_SPEED, 1'b0, 1'b0, 1'b0, 1'b0, 8'h00, 32'sh64);
    send(pmpg_pkg::PMPG_OP_RATE, 1'b0, 1'b0, 1'b0, 1'b0, 8'h00, 32'sh2);
    cap_spd = 100;
    cap_rate = 2;
    send(pmpg_pkg::PMPG_OP_MOVE, 1'b0, 1'b1, 1'b0, 1'b0, 8'h00, 32'sh14);
    send(pmpg_pkg::PMPG_OP_END, 1'b0, 1'b0, 1'b0, 1'b0, 8'h00, 32'sh0);
    wait_idle();
    chk_val(cmd_pos, 32'sh366);
    chk_val(cmd_vel, 32'sh0);
    chk_val(32'(prog_done), 32'sh1);
    give_verdict();
  end
endmodule
`default_nettype wire
